/* verilog/mmap_pkg.sv */
package mmap_pkg;
    // =====================================================
    // address map
    localparam logic [11:0] IO_LO       = 12'h000;
    localparam logic [11:0] IO_HI       = 12'h01f;
    localparam logic [11:0] RAM_LO      = 12'h0c0;
    localparam logic [11:0] RAM_HI      = 12'h0ff;
    localparam logic [11:0] ROM_LO      = 12'h300;
    localparam logic [11:0] ROM_HI      = 12'h7ff;
    localparam logic [11:0] TROM_LO     = 12'hf00;
    localparam logic [11:0] TROM_HI     = 12'hfef;
    localparam logic [11:0] VEC_LO      = 12'hff0;
    localparam logic [11:0] VEC_HI      = 12'hfff;
    localparam int          RAM_BYTES   = 64;
    localparam int          ROM_BYTES   = 1280;
    localparam int          VEC_BYTES   = 16;
    localparam int          TROM_BYTES  = 240;
    // =====================================================
    // register offsets
    localparam logic [11:0] OFS_PA_DATA = 12'h000;
    localparam logic [11:0] OFS_PB_DATA = 12'h001;
    localparam logic [11:0] OFS_PA_DIR  = 12'h004;
    localparam logic [11:0] OFS_PB_DIR  = 12'h005;
    localparam logic [11:0] OFS_TCS     = 12'h008;
    localparam logic [11:0] OFS_COUNT   = 12'h009;
    localparam logic [11:0] OFS_ICS     = 12'h00a;
    localparam logic [11:0] OFS_PA_PULL = 12'h010;
    localparam logic [11:0] OFS_PB_PULL = 12'h011;
    // =====================================================
    // field positions
    localparam int          SLOW_BIT    = 7;
    localparam int          OVF_BIT     = 7;
    localparam int          RTF_BIT     = 6;
    localparam int          OVF_EN_BIT  = 5;
    localparam int          TICK_EN_BIT = 4;
    localparam int          TOFC_BIT    = 3;
    localparam int          RTFC_BIT    = 2;
    localparam int          PIN_EN_BIT  = 7;
    localparam int          EDGE_EN_BIT = 6;
    localparam int          PIN_FL_BIT  = 3;
    localparam int          EDGE_FL_BIT = 2;
    localparam int          IRQA_BIT    = 1;
    localparam int          IRQA1_BIT   = 0;
    // =====================================================
    // reset values and masks
    localparam logic [7:0]  RST_ZERO    = 8'h00;
    localparam logic [7:0]  PB_MASK     = 8'h3f;
    localparam logic [7:0]  PB_DIR_MASK = 8'hbf;
    localparam logic [7:0]  PA_PU_MASK  = 8'hc0;
    localparam logic [7:0]  PB_PU_MASK  = 8'h06;
    localparam logic [7:0]  UNIMP_VAL   = 8'h00;

    typedef enum logic [2:0] {
        RGN_NONE = 3'b000,
        RGN_IO   = 3'b001,
        RGN_RAM  = 3'b010,
        RGN_ROM  = 3'b011,
        RGN_TROM = 3'b100,
        RGN_VEC  = 3'b101
    } region_t;

    typedef struct packed {
        logic [7:0] pa_out;
        logic [7:0] pa_oe_n;
        logic [7:0] pa_pull;
        logic [5:0] pb_out;
        logic [5:0] pb_oe_n;
        logic [5:0] pb_pull;
        logic       slow_edge_enable;
    } port_ctl_t;
endpackage

/* verilog/mcu_memory_map_io_decode.sv */
// Implementation choice: the strobed register port.
module mcu_memory_map_io_decode
    import mmap_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [7:0]    rdata,
    output logic      [2:0]    region,
    input  wire logic [7:0]    first_port_lines,
    input  wire logic [5:0]    second_port_lines,
    output logic      [7:0]    pa_out,
    output logic      [7:0]    pa_oe_n,
    output logic      [7:0]    pa_pull,
    output logic      [5:0]    pb_out,
    output logic      [5:0]    pb_oe_n,
    output logic      [5:0]    pb_pull,
    output logic               slow_edge_enable,
    input  wire logic [7:0]    timer_count,
    input  wire logic          timer_overflow_evt,
    input  wire logic          periodic_tick_evt,
    input  wire logic          ext_pin_evt,
    input  wire logic          port_edge_evt,
    output logic      [1:0]    tick_rate,
    output logic               timer_overflow_irq_en,
    output logic               periodic_tick_irq_en,
    output logic               ext_pin_irq_en,
    output logic               port_edge_irq_en,
    output logic               timer_overflow_flag,
    output logic               periodic_tick_flag,
    output logic               ext_pin_irq_flag,
    output logic               port_edge_irq_flag
);

    // =====================================================
    // decode
    function automatic region_t decode(input logic [11:0] a);
        if (a <= IO_HI) begin
            decode = RGN_IO;
        end else if (a >= RAM_LO && a <= RAM_HI) begin
            decode = RGN_RAM;
        end else if (a >= ROM_LO && a <= ROM_HI) begin
            decode = RGN_ROM;
        end else if (a >= TROM_LO && a <= TROM_HI) begin
            decode = RGN_TROM;
        end else if (a >= VEC_LO) begin
            decode = RGN_VEC;
        end else begin
            decode = RGN_NONE;
        end
    endfunction

    logic [11:0] a12;
    region_t     rgn;
    logic        io_wr;
    logic        ram_wr;
    assign a12    = 12'(addr);
    assign rgn    = decode(a12);
    assign io_wr  = wr && rgn == RGN_IO;
    assign ram_wr = wr && rgn == RGN_RAM;

    // =====================================================
    // pin synchronisers; first stage feeds only the second
    logic [7:0] pa_s1_r;
    logic [7:0] pa_s2_r;
    logic [5:0] pb_s1_r;
    logic [5:0] pb_s2_r;
    logic [3:0] ev_s1_r;
    logic [3:0] ev_s2_r;
    logic [3:0] ev_s3_r;
    logic [3:0] ev_pulse;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pa_s1_r <= RST_ZERO;
            pa_s2_r <= RST_ZERO;
            pb_s1_r <= 6'h00;
            pb_s2_r <= 6'h00;
            ev_s1_r <= 4'h0;
            ev_s2_r <= 4'h0;
            ev_s3_r <= 4'h0;
        end else begin
            pa_s1_r <= first_port_lines;
            pa_s2_r <= pa_s1_r;
            pb_s1_r <= second_port_lines;
            pb_s2_r <= pb_s1_r;
            ev_s1_r <= {port_edge_evt, ext_pin_evt, periodic_tick_evt, timer_overflow_evt};
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end
    // events are levels from outside; a rising edge sets the flag
    assign ev_pulse = ev_s2_r & ~ev_s3_r;

    // =====================================================
    // port registers
    logic [7:0] pa_data_r;
    logic [5:0] pb_data_r;
    logic [7:0] pa_dir_r;
    logic [5:0] pb_dir_r;
    logic       slow_r;
    logic [7:0] pa_pull_r;
    logic [5:0] pb_pull_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pa_data_r <= RST_ZERO;
            pb_data_r <= 6'h00;
            pa_dir_r  <= RST_ZERO;
            pb_dir_r  <= 6'h00;
            slow_r    <= 1'b0;
            pa_pull_r <= RST_ZERO;
            pb_pull_r <= 6'h00;
        end else if (io_wr) begin
            case (a12)
                OFS_PA_DATA: pa_data_r <= wdata;
                OFS_PB_DATA: pb_data_r <= wdata[5:0];
                OFS_PA_DIR:  pa_dir_r  <= wdata;
                OFS_PB_DIR: begin
                    pb_dir_r <= wdata[5:0];
                    slow_r   <= wdata[SLOW_BIT];
                end
                OFS_PA_PULL: pa_pull_r <= wdata;
                OFS_PB_PULL: pb_pull_r <= wdata[5:0];
                default: ;
            endcase
        end
    end

    // =====================================================
    // timer control/status
    logic [7:0] tcs_r;
    logic       ovf_set;
    logic       rtf_set;
    logic       ovf_clr;
    logic       rtf_clr;
    logic       tcs_wr;
    assign tcs_wr  = io_wr && a12 == OFS_TCS;
    assign ovf_set = ev_pulse[0];
    assign rtf_set = ev_pulse[1];
    assign ovf_clr = tcs_wr && wdata[TOFC_BIT];
    assign rtf_clr = tcs_wr && wdata[RTFC_BIT];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tcs_r <= RST_ZERO;
        end else begin
            // set wins over a clear in the same cycle
            tcs_r[OVF_BIT] <= ovf_set | (tcs_r[OVF_BIT] & ~ovf_clr);
            tcs_r[RTF_BIT] <= rtf_set | (tcs_r[RTF_BIT] & ~rtf_clr);
            if (tcs_wr) begin
                tcs_r[OVF_EN_BIT]  <= wdata[OVF_EN_BIT];
                tcs_r[TICK_EN_BIT] <= wdata[TICK_EN_BIT];
                tcs_r[1:0]      <= wdata[1:0];
            end
        end
    end

    // =====================================================
    // external interrupt control/status
    logic [7:0] ics_r;
    logic       ics_wr;
    assign ics_wr = io_wr && a12 == OFS_ICS;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ics_r <= RST_ZERO;
        end else begin
            ics_r[PIN_FL_BIT]  <= ev_pulse[2]
                                | (ics_r[PIN_FL_BIT] & ~(ics_wr & wdata[IRQA_BIT]));
            ics_r[EDGE_FL_BIT] <= ev_pulse[3]
                                | (ics_r[EDGE_FL_BIT] & ~(ics_wr & wdata[IRQA1_BIT]));
            if (ics_wr) begin
                ics_r[PIN_EN_BIT]  <= wdata[PIN_EN_BIT];
                ics_r[EDGE_EN_BIT] <= wdata[EDGE_EN_BIT];
            end
        end
    end

    // =====================================================
    // user RAM; stack wraps inside this page by cpu address math
    logic [7:0] ram_r [RAM_BYTES];
    always_ff @(posedge clock) begin
        if (ram_wr) begin
            ram_r[a12[5:0]] <= wdata;
        end
    end

    // =====================================================
    // read path; rom contents live outside, read as zero here
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = UNIMP_VAL;
        case (rgn)
            RGN_IO: begin
                case (a12)
                    OFS_PA_DATA: rd_nxt = (pa_data_r & pa_dir_r) | (pa_s2_r & ~pa_dir_r);
                    OFS_PB_DATA: rd_nxt = {2'b00, (pb_data_r & pb_dir_r)
                                                | (pb_s2_r & ~pb_dir_r)};
                    OFS_PA_DIR:  rd_nxt = pa_dir_r;
                    OFS_PB_DIR:  rd_nxt = {slow_r, 1'b0, pb_dir_r};
                    OFS_TCS:     rd_nxt = {tcs_r[7:4], 2'b00, tcs_r[1:0]};
                    OFS_COUNT:   rd_nxt = timer_count;
                    OFS_ICS:     rd_nxt = {ics_r[7:6], 2'b00, ics_r[3:2], 2'b00};
                    default:     rd_nxt = UNIMP_VAL;
                endcase
            end
            RGN_RAM: rd_nxt = ram_r[a12[5:0]];
            default: rd_nxt = UNIMP_VAL;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata  <= RST_ZERO;
            region <= RGN_NONE;
        end else begin
            if (rd) begin
                rdata <= rd_nxt;
            end
            if (rd || wr) begin
                region <= rgn;
            end
        end
    end

    // =====================================================
    // pin control, registered
    port_ctl_t ctl_nxt;
    always_comb begin
        ctl_nxt.pa_out  = pa_data_r;
        ctl_nxt.pa_oe_n = ~pa_dir_r;
        // pull-ups stay on; pull-downs only on inputs
        ctl_nxt.pa_pull = (pa_pull_r & PA_PU_MASK)
                        | (pa_pull_r & ~PA_PU_MASK & ~pa_dir_r);
        ctl_nxt.pb_out  = pb_data_r;
        ctl_nxt.pb_oe_n = ~pb_dir_r;
        ctl_nxt.pb_pull = (pb_pull_r & PB_PU_MASK[5:0])
                        | (pb_pull_r & ~PB_PU_MASK[5:0] & ~pb_dir_r);
        ctl_nxt.slow_edge_enable = slow_r;
    end

    port_ctl_t ctl_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= '{pa_out: 8'h00, pa_oe_n: 8'hff, pa_pull: 8'h00, pb_out: 6'h00,
                       pb_oe_n: 6'h3f, pb_pull: 6'h00, slow_edge_enable: 1'b0};
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    assign pa_out                = ctl_r.pa_out;
    assign pa_oe_n               = ctl_r.pa_oe_n;
    assign pa_pull               = ctl_r.pa_pull;
    assign pb_out                = ctl_r.pb_out;
    assign pb_oe_n               = ctl_r.pb_oe_n;
    assign pb_pull               = ctl_r.pb_pull;
    assign slow_edge_enable      = ctl_r.slow_edge_enable;
    assign tick_rate             = tcs_r[1:0];
    assign timer_overflow_irq_en = tcs_r[OVF_EN_BIT];
    assign periodic_tick_irq_en  = tcs_r[TICK_EN_BIT];
    assign timer_overflow_flag   = tcs_r[OVF_BIT];
    assign periodic_tick_flag    = tcs_r[RTF_BIT];
    assign ext_pin_irq_en        = ics_r[PIN_EN_BIT];
    assign port_edge_irq_en      = ics_r[EDGE_EN_BIT];
    assign ext_pin_irq_flag      = ics_r[PIN_FL_BIT];
    assign port_edge_irq_flag    = ics_r[EDGE_FL_BIT];

    // =====================================================
    // assertions
    property p_io_dir;
        @(posedge clock) disable iff (!rstn)
        (wr && a12 == OFS_PA_DIR) |=> (pa_dir_r == $past(wdata)) ##1 (pa_oe_n == ~$past(wdata, 2));
    endproperty
    a_io_dir: assert property (p_io_dir) else $error("direction write lost");

    property p_pb_data_top;
        @(posedge clock) disable iff (!rstn)
        $past(rd && a12 == OFS_PB_DATA) |-> rdata[7:6] == 2'b00;
    endproperty
    a_pb_data_top: assert property (p_pb_data_top) else $error("port b top bits set");

    property p_pb_dir_read;
        @(posedge clock) disable iff (!rstn)
        (wr && a12 == OFS_PB_DIR) ##1 !wr ##1 (rd && a12 == OFS_PB_DIR)
        |=> rdata == ($past(wdata, 3) & PB_DIR_MASK);
    endproperty
    a_pb_dir_read: assert property (p_pb_dir_read) else $error("port b dir readback");

    property p_tcs_clr_read;
        @(posedge clock) disable iff (!rstn)
        $past(rd && a12 == OFS_TCS) |-> rdata[3:2] == 2'b00;
    endproperty
    a_tcs_clr_read: assert property (p_tcs_clr_read) else $error("clear bits read one");

    property p_ovf_set_wins;
        @(posedge clock) disable iff (!rstn)
        ovf_set |=> timer_overflow_flag;
    endproperty
    a_ovf_set_wins: assert property (p_ovf_set_wins) else $error("overflow flag lost");

    property p_count_read;
        @(posedge clock) disable iff (!rstn)
        (rd && a12 == OFS_COUNT) |=> rdata == $past(timer_count);
    endproperty
    a_count_read: assert property (p_count_read) else $error("counter readback");

    property p_ics_read;
        @(posedge clock) disable iff (!rstn)
        $past(rd && a12 == OFS_ICS) |-> (rdata & 8'h33) == 8'h00;
    endproperty
    a_ics_read: assert property (p_ics_read) else $error("irq register zero bits");

    property p_pull_wo;
        @(posedge clock) disable iff (!rstn)
        (rd && (a12 == OFS_PA_PULL || a12 == OFS_PB_PULL)) |=> rdata == UNIMP_VAL;
    endproperty
    a_pull_wo: assert property (p_pull_wo) else $error("pull register readable");

    property p_ram_rw;
        @(posedge clock) disable iff (!rstn)
        (wr && rgn == RGN_RAM) ##1 !wr ##1 (rd && a12 == $past(a12, 2))
        |=> rdata == $past(wdata, 3);
    endproperty
    a_ram_rw: assert property (p_ram_rw) else $error("ram readback");

    property p_pulldown_out;
        @(posedge clock) disable iff (!rstn)
        (pa_dir_r[0] && $stable(pa_dir_r)) |=> !pa_pull[0];
    endproperty
    a_pulldown_out: assert property (p_pulldown_out) else $error("pull-down on output");

    property p_edge_set_wins;
        @(posedge clock) disable iff (!rstn)
        ev_pulse[3] |=> port_edge_irq_flag;
    endproperty
    a_edge_set_wins: assert property (p_edge_set_wins) else $error("port edge flag lost");

    property p_region_reg;
        @(posedge clock) disable iff (!rstn)
        (rd || wr) |=> region == $past(rgn);
    endproperty
    a_region_reg: assert property (p_region_reg) else $error("region not registered");

    c_ram_wr:   cover property (@(posedge clock) disable iff (!rstn) ram_wr);
    c_ovf_clr:  cover property (@(posedge clock) disable iff (!rstn) ovf_clr && ovf_set);
    c_irq_ack:  cover property (@(posedge clock) disable iff (!rstn)
                                ext_pin_irq_flag ##1 !ext_pin_irq_flag);
    c_ram_back: cover property (@(posedge clock) disable iff (!rstn)
                                ram_wr ##1 !wr ##1 (rd && rgn == RGN_RAM));
endmodule

/* tb/cpu_bus_model.sv */
module cpu_bus_model (
    input  wire logic        clock,
    output logic      [11:0] addr,
    output logic      [7:0]  wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [7:0]  rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr  = 12'h000;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // =====================================================
    // single-byte cycles, one strobe cycle each
    task automatic write_byte(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
        // bus not held after the cycle, so stale values cannot hide a late sample
        addr  <= ~a;
        wdata <= ~d;
    endtask

    task automatic read_byte(input logic [11:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

/* tb/mcu_memory_map_io_decode_tb_top.sv */
module mcu_memory_map_io_decode_tb_top import mmap_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock = 1'b0;
    logic        rstn  = 1'b0;
    logic [11:0] addr;
    logic [7:0]  wdata, rdata, pa_out, pa_oe_n, pa_pull;
    logic        wr, rd, slow, ovf_en, tick_en, pin_en, edge_en;
    logic        ovf_flag, tick_flag, pin_flag, edge_flag;
    logic [2:0]  region;
    logic [5:0]  pb_out, pb_oe_n, pb_pull;
    logic [1:0]  tick_rate;
    logic [7:0]  pins_a = 8'h5a;
    logic [5:0]  pins_b = 6'h2d;
    logic [7:0]  tcount = 8'h96;
    logic        ev_ovf = 1'b0, ev_rt = 1'b0, ev_ext = 1'b0, ev_edge = 1'b0;
    int          err_total = 0;
    int          check_count = 0;
    localparam logic [11:0] MAP_A [15] = '{12'h01f, 12'h020, 12'h0bf, 12'h0c0, 12'h0ff,
        12'h100, 12'h2ff, 12'h300, 12'h7ff, 12'h800, 12'heff, 12'hf00, 12'hfef, 12'hff0, 12'hfff};
    localparam logic [11:0] GAP_A [8] = '{12'h002, 12'h003, 12'h006, 12'h007,
        12'h00b, 12'h00f, 12'h012, 12'h01f};

    always #20 clock = ~clock;

    cpu_bus_model cpu_u (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));

    mcu_memory_map_io_decode #(.AW(12)) dut_u (
        .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .region(region), .first_port_lines(pins_a),
        .second_port_lines(pins_b), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa_pull(pa_pull),
        .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pull(pb_pull), .slow_edge_enable(slow),
        .timer_count(tcount), .timer_overflow_evt(ev_ovf), .periodic_tick_evt(ev_rt),
        .ext_pin_evt(ev_ext), .port_edge_evt(ev_edge), .tick_rate(tick_rate),
        .timer_overflow_irq_en(ovf_en), .periodic_tick_irq_en(tick_en),
        .ext_pin_irq_en(pin_en), .port_edge_irq_en(edge_en),
        .timer_overflow_flag(ovf_flag), .periodic_tick_flag(tick_flag),
        .ext_pin_irq_flag(pin_flag), .port_edge_irq_flag(edge_flag));

    // =====================================================
    // reporting
    task automatic stop_test();
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        cpu_u.read_byte(a, d);
        check8(name, exp, d);
    endtask

    task automatic settle();
        @(posedge clock);
        #1;
    endtask

    function automatic logic [2:0] exp_region(input logic [11:0] a);
        if (a <= IO_HI) return 3'h1;
        if (a >= RAM_LO && a <= RAM_HI) return 3'h2;
        if (a >= ROM_LO && a <= ROM_HI) return 3'h3;
        if (a >= TROM_LO && a <= TROM_HI) return 3'h4;
        if (a >= VEC_LO) return 3'h5;
        return 3'h0;
    endfunction

    // =====================================================
    // scenarios
    task automatic t_reset();
        rstn <= 1'b0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        #1;
        check8("pa_oe_n", 8'hff, pa_oe_n);
        check8("pb_oe_n", 8'h3f, {2'b00, pb_oe_n});
        rd_chk(12'h004, 8'h00, "pa_dir");
        rd_chk(12'h005, 8'h00, "pb_dir");
    endtask

    task automatic t_ports();
        cpu_u.write_byte(12'h004, 8'hff);
        cpu_u.write_byte(12'h000, 8'ha5);
        settle();
        check8("pa_oe_n", 8'h00, pa_oe_n);
        check8("pa_out", 8'ha5, pa_out);
        rd_chk(12'h000, 8'ha5, "pa_data");
        cpu_u.write_byte(12'h005, 8'hff);
        rd_chk(12'h005, 8'hbf, "pb_dir");
        cpu_u.write_byte(12'h001, 8'hff);
        check8("slow", 8'h01, {7'h00, slow});
        rd_chk(12'h001, 8'h3f, "pb_data");
        check8("pb_out", 8'h3f, {2'b00, pb_out});
        cpu_u.write_byte(12'h004, 8'h0f);
        rd_chk(12'h000, 8'h55, "pa_mixed");
        cpu_u.write_byte(12'h010, 8'hff);
        cpu_u.write_byte(12'h011, 8'hff);
        settle();
        check8("pa_pull", 8'hf0, pa_pull);
        check8("pb_pull", 8'h06, {2'b00, pb_pull});
        rd_chk(12'h010, 8'h00, "pa_pull_rd");
        cpu_u.write_byte(12'h005, 8'h00);
        settle();
        check8("pb_pull_in", 8'h3f, {2'b00, pb_pull});
        check8("slow_off", 8'h00, {7'h00, slow});
        rd_chk(12'h001, 8'h2d, "pb_pins");
    endtask

    task automatic t_timer();
        rd_chk(12'h009, 8'h96, "count");
        cpu_u.write_byte(12'h009, 8'h00);
        rd_chk(12'h009, 8'h96, "count_wr");
        cpu_u.write_byte(12'h008, 8'hff);
        rd_chk(12'h008, 8'h33, "tcs");
        check8("tcs_out", 8'h33, {ovf_flag, tick_flag, ovf_en, tick_en, 2'b00, tick_rate});
        // clear of both flags taken in the cycle the synced edges arrive: set must win
        @(posedge clock);
        ev_ovf <= 1'b1;
        ev_rt  <= 1'b1;
        @(posedge clock);
        cpu_u.write_byte(12'h008, 8'hff);
        rd_chk(12'h008, 8'hf3, "tcs_flags");
        cpu_u.write_byte(12'h008, 8'h3b);
        rd_chk(12'h008, 8'h73, "tcs_clr_ovf");
        cpu_u.write_byte(12'h008, 8'h37);
        rd_chk(12'h008, 8'h33, "tcs_clr_tick");
    endtask

    task automatic t_irq();
        cpu_u.write_byte(12'h00a, 8'hff);
        rd_chk(12'h00a, 8'hc0, "ics");
        @(posedge clock);
        ev_ext  <= 1'b1;
        ev_edge <= 1'b1;
        repeat (5) @(posedge clock);
        rd_chk(12'h00a, 8'hcc, "ics_flags");
        cpu_u.write_byte(12'h00a, 8'hc2);
        rd_chk(12'h00a, 8'hc4, "ics_ack_ext");
        cpu_u.write_byte(12'h00a, 8'hc1);
        rd_chk(12'h00a, 8'hc0, "ics_ack_edge");
        check8("ics_out", 8'hc0, {pin_en, edge_en, 2'b00, pin_flag, edge_flag, 2'b00});
    endtask

    task automatic t_map();
        logic [7:0] d;
        foreach (GAP_A[i]) begin
            cpu_u.write_byte(GAP_A[i], 8'hff);
            rd_chk(GAP_A[i], 8'h00, "gap");
        end
        foreach (MAP_A[i]) begin
            cpu_u.read_byte(MAP_A[i], d);
            check8("region", {5'h00, exp_region(MAP_A[i])}, {5'h00, region});
            if (exp_region(MAP_A[i]) != 3'h2) begin
                check8("rom_data", 8'h00, d);
            end
        end
        cpu_u.write_byte(12'h300, 8'h77);
        rd_chk(12'h300, 8'h00, "rom_wr");
    endtask

    task automatic t_ram();
        for (int i = 0; i < 64; i++) begin
            cpu_u.write_byte(RAM_HI - 12'(i), 8'(i) ^ 8'h5a);
        end
        for (int i = 0; i < 64; i++) begin
            rd_chk(RAM_HI - 12'(i), 8'(i) ^ 8'h5a, "ram");
        end
        cpu_u.write_byte(RAM_LO, 8'hc3);
        rd_chk(RAM_LO, 8'hc3, "ram_back");
    endtask

    initial begin
        t_reset();
        t_ports();
        t_reset();
        t_timer();
        t_irq();
        t_map();
        t_ram();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        stop_test();
    end
endmodule
